// >>> verif/owsr_regs_monitor.sv
// checker: bus timing, offset scaling and live status reads of the register bank
`timescale 1ns/1ns
module owsr_regs_mon
   import owsr_pkg::*;
(
   // clock and reset
   input wire logic                   clk_i,
   input wire logic                   rst_i,
   // watched ports
   input wire owsr_pkg::owsr_wb_req_t wb_req_i,
   input wire owsr_pkg::owsr_status_t status_i,
   input wire logic signed [7:0]      ch_code_i [7],
   input wire logic [31:0]            wb_dat_o,
   input wire logic                   wb_ack_o,
   input wire logic [1:0]             offset_step_scale_o,
   input wire logic signed [19:0]     ch_offset_o [7],
   input wire logic                   irq_o
);
   // ==========================================================
   // helpers
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   logic req;
   logic rd_cal;
   logic rd_pll;
   assign req    = wb_req_i.cyc && wb_req_i.stb;
   assign rd_cal = req && !wb_req_i.we && wb_req_i.adr == 11'h300 && wb_ack_o;
   assign rd_pll = req && !wb_req_i.we && wb_req_i.adr == 11'h344 && wb_ack_o;
   // six stable cycles cover two sync flops plus read capture
   property p_set(logic s, logic rd, logic d);
      s[*6] ##0 rd |-> d;
   endproperty
   // ==========================================================
   // assertions
   a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
   a_ack_after_take: assert property (req && !wb_ack_o |=> wb_ack_o) else $error("ack missing");
   a_ack_has_req: assert property (wb_ack_o |-> $past(req)) else $error("ack without request");
   a_dat_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0) else $error("upper data");
   a_offset_scaled: assert property (
      $stable(ch_code_i[0]) && $stable(offset_step_scale_o) |=> ch_offset_o[0] ==
      (20'($past(ch_code_i[0])) <<< $past(offset_step_scale_o))) else $error("offset scale");
   a_cal_done_live: assert property (p_set(status_i.cal_done, rd_cal, wb_dat_o[7]))
      else $error("cal done bit");
   a_pll_cal_live: assert property (p_set(status_i.pll_cal_done, rd_pll, wb_dat_o[5]))
      else $error("pll cal bit");
   a_drift_low_live: assert property (p_set(status_i.pll_low, rd_pll, wb_dat_o[2]))
      else $error("drift low bit");
   a_drift_high_live: assert property (p_set(status_i.pll_high, rd_pll, wb_dat_o[1]))
      else $error("drift high bit");
   a_drift_low_clear: assert property (p_set(!status_i.pll_low, rd_pll, !wb_dat_o[2]))
      else $error("drift low latched");
   c_pll_read: cover property (rd_pll);
   c_write: cover property (wb_ack_o && wb_req_i.we);
   c_irq: cover property ($rose(irq_o));
endmodule

bind owsr_regs owsr_regs_mon i_mon (.clk_i, .rst_i, .wb_req_i, .status_i, .ch_code_i, .wb_dat_o,
   .wb_ack_o, .offset_step_scale_o, .ch_offset_o, .irq_o);

// >>> verif/owsr_regs_tb.sv
// testbench: reset values, weight scaling, read-only places, status and interrupt
`timescale 1ns/1ns
module owsr_regs_tb;
   import owsr_pkg::*;
   logic               clk_i = 1'b0;
   logic               rst_i = 1'b1;
   owsr_wb_req_t       req   = '0;
   owsr_status_t       st    = '0;
   logic signed [7:0]  code [7] = '{default: 8'h00};
   logic [31:0]        dat;
   logic               ack, irq;
   logic [1:0]         scale;
   logic signed [19:0] o7;
   logic signed [19:0] ofs [7];
   logic [2:0]         thi, tlo;
   logic [7:0]         rd;
   int                 fail_count = 0;
   int                 checks = 0;
   always #5 clk_i = ~clk_i;
   owsr_regs i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(req), .wb_dat_o(dat), .wb_ack_o(ack),
      .status_i(st), .ch_code_i(code), .offset_step_scale_o(scale), .ch7_offset_o(o7),
      .ch_offset_o(ofs), .factory_trim_bits_hi_o(thi), .factory_trim_bits_lo_o(tlo), .irq_o(irq));
   // ==========================================================
   // tasks
   task end_of_test;
      if (fail_count == 0 && checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task chk(input logic [19:0] seen, input logic [19:0] exp);
      checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("FAIL %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // one classic cycle; request held until ack is seen at a rising edge
   task xfer(input logic [10:0] a, input logic we, input logic [7:0] d);
      int n;
      req.adr <= a;
      req.dat <= {24'h0, d};
      req.sel <= 4'hF;
      req.we  <= we;
      req.cyc <= 1'b1;
      req.stb <= 1'b1;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack !== 1'b1 && n < 20);
      if (ack !== 1'b1) begin
         fail_count++;
         $display("FAIL %0t bus timeout", $time);
         end_of_test;
      end
      rd = dat[7:0];
      req.cyc <= 1'b0;
      req.stb <= 1'b0;
      @(posedge clk_i);
   endtask
   task rchk(input logic [10:0] a, input logic [7:0] m, input logic [7:0] exp);
      xfer(a, 1'b0, 8'h00);
      chk(rd & m, exp);
   endtask
   // ==========================================================
   // sequence
   initial begin
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      rchk(11'h294, 8'hFF, 8'h00);
      rchk(11'h29C, 8'hFF, 8'h47);
      chk(thi, 3'b010);
      chk(tlo, 3'b111);
      rchk(11'h300, 8'hFF, 8'h00);
      rchk(11'h100, 8'hFF, 8'h00);
      for (int w = 0; w < 4; w++) begin
         for (int c = 0; c < 7; c++) code[c] <= 8'(-3 - c);
         xfer(11'h29C, 1'b1, {3'b010, 2'(w), 3'b111});
         xfer(11'h294, 1'b1, 8'h81);
         rchk(11'h294, 8'hFF, 8'h81);
         @(negedge clk_i);
         chk(scale, 20'(w));
         chk(o7, 20'(-127 <<< w));
         chk(ofs[3], 20'(-6 <<< w));
         @(posedge clk_i);
      end
      st <= '1;
      repeat (8) @(posedge clk_i);
      chk(irq, 1'b0);
      xfer(11'h300, 1'b1, 8'h00);
      xfer(11'h570, 1'b1, 8'h00);
      rchk(11'h300, 8'h80, 8'h80);
      rchk(11'h570, 8'hFF, OWSR_IDENT_DEF[7:0]);
      rchk(11'h574, 8'hFF, OWSR_IDENT_DEF[15:8]);
      rchk(11'h344, 8'h26, 8'h26);
      rchk(11'h7C0, 8'h0F, 8'h0F);
      st.pll_low  <= 1'b0;
      st.pll_high <= 1'b0;
      repeat (8) @(posedge clk_i);
      rchk(11'h344, 8'h26, 8'h20);
      xfer(11'h7C4, 1'b1, 8'h04);
      @(negedge clk_i);
      chk(irq, 1'b1);
      @(posedge clk_i);
      xfer(11'h7C0, 1'b1, 8'h04);
      @(negedge clk_i);
      chk(irq, 1'b0);
      rchk(11'h7C0, 8'h0F, 8'h0B);
      end_of_test;
   end
endmodule

// >>> verilog/owsr_pkg.sv
// package: register map, field layout, reset values and carrier types of the offset/status bank
package owsr_pkg;

   // ==========================================================
   // register word indices (byte address = index * 4, e.g. 0xA5 -> 0x294, 0xC0 -> 0x300)
   localparam logic [8:0]  OWSR_IDX_CH7_OFS   = 9'h0A5;
   localparam logic [8:0]  OWSR_IDX_WEIGHT    = 9'h0A7;
   localparam logic [8:0]  OWSR_IDX_CAL_STAT  = 9'h0C0;
   localparam logic [8:0]  OWSR_IDX_PLL_STAT  = 9'h0D1;
   localparam logic [8:0]  OWSR_IDX_IDENT_LO  = 9'h15C;
   localparam logic [8:0]  OWSR_IDX_IDENT_HI  = 9'h15D;
   localparam logic [8:0]  OWSR_IDX_IRQ_STAT  = 9'h1F0;
   localparam logic [8:0]  OWSR_IDX_IRQ_MASK  = 9'h1F1;
   localparam int          OWSR_ADDR_W        = 11;

   // ==========================================================
   // field positions
   localparam int          OWSR_WT_LSB        = 3;
   localparam int          OWSR_WT_MSB        = 4;
   localparam int          OWSR_CAL_DONE_BIT  = 7;
   localparam int          OWSR_PLL_CAL_BIT   = 5;
   localparam int          OWSR_PLL_LOW_BIT   = 2;
   localparam int          OWSR_PLL_HIGH_BIT  = 1;

   // ==========================================================
   // reset values
   localparam logic [7:0]  OWSR_CH7_RST       = 8'h00;
   localparam logic [7:0]  OWSR_WEIGHT_RST    = 8'h47;
   localparam logic [7:0]  OWSR_CAL_RST       = 8'h00;
   localparam logic [3:0]  OWSR_IRQ_RST       = 4'h0;
   // arbitrary identity value, not a real part code
   localparam logic [15:0] OWSR_IDENT_DEF     = 16'h5A01;

   // ==========================================================
   // interrupt bit positions (status and mask share layout)
   localparam int          OWSR_IRQ_CAL       = 0;
   localparam int          OWSR_IRQ_PLLCAL    = 1;
   localparam int          OWSR_IRQ_LOW       = 2;
   localparam int          OWSR_IRQ_HIGH      = 3;
   localparam int          OWSR_IRQ_N         = 4;

   typedef enum logic [1:0] {
      OWSR_STEP_QUARTER = 2'b00,
      OWSR_STEP_HALF    = 2'b01,
      OWSR_STEP_ONE     = 2'b10,
      OWSR_STEP_TWO     = 2'b11
   } owsr_step_t;

   // ==========================================================
   // carriers
   typedef struct packed {
      logic [OWSR_ADDR_W-1:0] adr;
      logic [31:0]            dat;
      logic [3:0]             sel;
      logic                   we;
      logic                   cyc;
      logic                   stb;
   } owsr_wb_req_t;

   typedef struct packed {
      logic                   cal_done;
      logic                   pll_cal_done;
      logic                   pll_low;
      logic                   pll_high;
   } owsr_status_t;

   typedef struct packed {
      logic [7:0]             ch7_code;
      logic [7:0]             weight;
      logic [1:0]             cal_sync;
      logic [1:0]             pcal_sync;
      logic [1:0]             low_sync;
      logic [1:0]             high_sync;
      logic [3:0]             prev;
      logic [OWSR_IRQ_N-1:0]  irq_stat;
      logic [OWSR_IRQ_N-1:0]  irq_mask;
      logic                   ack;
      logic [31:0]            rdat;
      logic signed [19:0]     ofs;
      logic [6:0][19:0]       ch_ofs;
   } owsr_state_t;

endpackage

// >>> verilog/owsr_regs.sv
// offset weight, calibration/pll status and identity register bank on classic wishbone
//
// Local design decision: the Wishbone register port.
`timescale 1ns/1ns

module owsr_regs
   import owsr_pkg::*;
#(
   parameter logic [15:0] IDENT = OWSR_IDENT_DEF
) (
   // clock and reset
   input  wire logic                     clk_i,
   input  wire logic                     rst_i,
   // wishbone slave
   input  wire owsr_pkg::owsr_wb_req_t   wb_req_i,
   output logic [31:0]                   wb_dat_o,
   output logic                          wb_ack_o,
   // status from converter core (asynchronous levels)
   input  wire owsr_pkg::owsr_status_t   status_i,
   // channel codes in, control out to datapath
   input  wire logic signed [7:0]        ch_code_i [7],
   output logic [1:0]                    offset_step_scale_o,
   output logic signed [19:0]            ch7_offset_o,
   output logic signed [19:0]            ch_offset_o [7],
   output logic [2:0]                    factory_trim_bits_hi_o,
   output logic [2:0]                    factory_trim_bits_lo_o,
   // interrupt
   output logic                          irq_o
);
   import owsr_pkg::*;

   // ==========================================================
   // state
   owsr_state_t           s_reg;
   owsr_state_t           s_next;

   // ==========================================================
   // bus decode signals
   logic [8:0]            idx;
   logic                  acc;
   logic                  rd_acc;
   logic                  wr;
   logic [7:0]            wbyte;

   logic                  hit_ch7;
   logic                  hit_wt;
   logic                  hit_cal;
   logic                  hit_pll;
   logic                  hit_id_lo;
   logic                  hit_id_hi;
   logic                  hit_istat;
   logic                  hit_imask;

   logic                  wr_ch7;
   logic                  wr_wt;
   logic                  wr_istat;
   logic                  wr_imask;

   // ==========================================================
   // status and interrupt signals
   logic [OWSR_IRQ_N-1:0] live;
   logic [OWSR_IRQ_N-1:0] rise;
   logic [OWSR_IRQ_N-1:0] clr;
   logic [OWSR_IRQ_N-1:0] stat_nx;
   logic [OWSR_IRQ_N-1:0] mask_nx;
   logic [7:0]            cal_byte;
   logic [7:0]            pll_byte;

   // ==========================================================
   // register, read and offset signals
   logic [7:0]            ch7_nx;
   logic [7:0]            weight_nx;
   logic [7:0]            rd_byte;
   logic [1:0]            wt_field;
   logic signed [19:0]    ch7_scaled;
   logic signed [19:0]    ch_scaled [7];

   genvar                 b;
   genvar                 g;

   // ==========================================================
   // offset scaling in quarter-lsb units; digital gain is applied downstream
   function automatic logic signed [19:0] scale(input logic signed [7:0] code,
                                                input logic [1:0]        wt);
      logic signed [19:0] ext;
      owsr_step_t         step;
      ext  = 20'(code);
      step = owsr_step_t'(wt);
      case (step)
         OWSR_STEP_QUARTER: begin
            scale = ext;
         end
         OWSR_STEP_HALF: begin
            scale = ext <<< 2'h1;
         end
         OWSR_STEP_ONE: begin
            scale = ext <<< 2'h2;
         end
         OWSR_STEP_TWO: begin
            scale = ext <<< 2'h3;
         end
         default: begin
            scale = ext;
         end
      endcase
   endfunction

   // ==========================================================
   // bus decode; ack gating leaves one idle cycle between accesses
   assign idx      = wb_req_i.adr[OWSR_ADDR_W-1:2];
   assign acc      = wb_req_i.cyc && wb_req_i.stb && !s_reg.ack;
   assign rd_acc   = acc && !wb_req_i.we;
   assign wr       = acc && wb_req_i.we && wb_req_i.sel[0];
   assign wbyte    = wb_req_i.dat[7:0];

   assign wr_ch7   = wr && hit_ch7;
   assign wr_wt    = wr && hit_wt;
   assign wr_istat = wr && hit_istat;
   assign wr_imask = wr && hit_imask;

   always_comb begin
      hit_ch7   = 1'b0;
      hit_wt    = 1'b0;
      hit_cal   = 1'b0;
      hit_pll   = 1'b0;
      hit_id_lo = 1'b0;
      hit_id_hi = 1'b0;
      hit_istat = 1'b0;
      hit_imask = 1'b0;
      case (idx)
         OWSR_IDX_CH7_OFS: begin
            hit_ch7 = 1'b1;
         end
         OWSR_IDX_WEIGHT: begin
            hit_wt = 1'b1;
         end
         OWSR_IDX_CAL_STAT: begin
            hit_cal = 1'b1;
         end
         OWSR_IDX_PLL_STAT: begin
            hit_pll = 1'b1;
         end
         OWSR_IDX_IDENT_LO: begin
            hit_id_lo = 1'b1;
         end
         OWSR_IDX_IDENT_HI: begin
            hit_id_hi = 1'b1;
         end
         OWSR_IDX_IRQ_STAT: begin
            hit_istat = 1'b1;
         end
         OWSR_IDX_IRQ_MASK: begin
            hit_imask = 1'b1;
         end
         default: begin
            hit_ch7 = 1'b0;
         end
      endcase
   end

   // ==========================================================
   // status: only the second flop of each synchroniser is read
   assign live[OWSR_IRQ_CAL]    = s_reg.cal_sync[1];
   assign live[OWSR_IRQ_PLLCAL] = s_reg.pcal_sync[1];
   assign live[OWSR_IRQ_LOW]    = s_reg.low_sync[1];
   assign live[OWSR_IRQ_HIGH]   = s_reg.high_sync[1];

   // sticky events; a rise in the cycle of a clear wins
   generate
      for (b = 0; b < OWSR_IRQ_N; b++) begin : g_evt
         assign rise[b]    = live[b] && !s_reg.prev[b];
         assign stat_nx[b] = rise[b] || (s_reg.irq_stat[b] && !clr[b]);
      end
   endgenerate

   always_comb begin
      cal_byte                    = OWSR_CAL_RST;
      cal_byte[OWSR_CAL_DONE_BIT] = live[OWSR_IRQ_CAL];
   end

   // drift bits follow the live level, nothing is latched
   always_comb begin
      pll_byte                    = 8'h00;
      pll_byte[OWSR_PLL_CAL_BIT]  = live[OWSR_IRQ_PLLCAL];
      pll_byte[OWSR_PLL_LOW_BIT]  = live[OWSR_IRQ_LOW];
      pll_byte[OWSR_PLL_HIGH_BIT] = live[OWSR_IRQ_HIGH];
   end

   // ==========================================================
   // register writes; writes to read-only places are dropped
   always_comb begin
      ch7_nx    = s_reg.ch7_code;
      weight_nx = s_reg.weight;
      mask_nx   = s_reg.irq_mask;
      clr       = '0;
      if (wr_ch7) begin
         ch7_nx = wbyte;
      end
      // trim bits stored as written; keeping them is the host's job
      if (wr_wt) begin
         weight_nx = wbyte;
      end
      if (wr_istat) begin
         clr = wbyte[OWSR_IRQ_N-1:0];
      end
      if (wr_imask) begin
         mask_nx = wbyte[OWSR_IRQ_N-1:0];
      end
   end

   // ==========================================================
   // read mux; unmapped places read as zero
   always_comb begin
      rd_byte = 8'h00;
      if (hit_ch7) begin
         rd_byte = s_reg.ch7_code;
      end else if (hit_wt) begin
         rd_byte = s_reg.weight;
      end else if (hit_cal) begin
         rd_byte = cal_byte;
      end else if (hit_pll) begin
         rd_byte = pll_byte;
      end else if (hit_id_lo) begin
         rd_byte = IDENT[7:0];
      end else if (hit_id_hi) begin
         rd_byte = IDENT[15:8];
      end else if (hit_istat) begin
         rd_byte = {4'h0, s_reg.irq_stat};
      end else if (hit_imask) begin
         rd_byte = {4'h0, s_reg.irq_mask};
      end else begin
         rd_byte = 8'h00;
      end
   end

   // ==========================================================
   // offsets: one step field scales every channel alike
   assign wt_field   = s_reg.weight[OWSR_WT_MSB:OWSR_WT_LSB];
   assign ch7_scaled = scale(s_reg.ch7_code, wt_field);

   generate
      for (g = 0; g < 7; g++) begin : g_ch
         assign ch_scaled[g]   = scale(ch_code_i[g], wt_field);
         assign ch_offset_o[g] = s_reg.ch_ofs[g];
      end
   endgenerate

   // ==========================================================
   // next state; the synchronous reset overrides every field
   always_comb begin
      s_next           = s_reg;
      s_next.cal_sync  = {s_reg.cal_sync[0], status_i.cal_done};
      s_next.pcal_sync = {s_reg.pcal_sync[0], status_i.pll_cal_done};
      s_next.low_sync  = {s_reg.low_sync[0], status_i.pll_low};
      s_next.high_sync = {s_reg.high_sync[0], status_i.pll_high};
      s_next.prev      = live;
      s_next.ch7_code  = ch7_nx;
      s_next.weight    = weight_nx;
      s_next.irq_mask  = mask_nx;
      s_next.irq_stat  = stat_nx;
      s_next.ack       = acc;
      s_next.rdat      = 32'h0000_0000;
      if (rd_acc) begin
         s_next.rdat[7:0] = rd_byte;
      end
      s_next.ofs       = ch7_scaled;
      for (int i = 0; i < 7; i++) begin
         s_next.ch_ofs[i] = ch_scaled[i];
      end
      if (rst_i) begin
         s_next          = '0;
         s_next.ch7_code = OWSR_CH7_RST;
         s_next.weight   = OWSR_WEIGHT_RST;
         s_next.irq_stat = OWSR_IRQ_RST;
         s_next.irq_mask = OWSR_IRQ_RST;
      end
   end

   always_ff @(posedge clk_i) begin
      s_reg <= s_next;
   end

   // ==========================================================
   // outputs, all but irq_o taken straight from flops; irq_o ORs the masked status flops
   assign wb_dat_o               = s_reg.rdat;
   assign wb_ack_o               = s_reg.ack;
   assign offset_step_scale_o    = wt_field;
   assign ch7_offset_o           = s_reg.ofs;
   assign factory_trim_bits_hi_o = s_reg.weight[7:5];
   assign factory_trim_bits_lo_o = s_reg.weight[2:0];
   assign irq_o                  = |(s_reg.irq_stat & s_reg.irq_mask);

endmodule
